// File: hdl/uotg_session.sv
`timescale 1ns/100ps
// Notes on behaviour
// - VBUS below session end sets session-end flag
// - discharge control drives VBUS discharge resistor
// - VBUS pulse control drives VBUS pulse
// - host negotiation only at full speed (full speed is only reported in the status register and gates nothing)
// - host handback, A detects 3 ms idle
// - comparator disable selects external comparator pins
// - select bit picks two or three pins
// - two-pin pattern decode of VBUS level
// - three-pin pattern decode of VBUS level
// - registers use low byte except PWM
// - page pointer 8 bits, bit 0 zero
// - frame number 11 bits over two registers
// - PWM reload: duty high byte, period low
module uotg_session #(
  parameter int IDLE_CYCLES  = uotg_pkg::IDLE_CYC,
  parameter int FRAME_CYCLES = uotg_pkg::FRAME_CYC
) (
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  input  wire uotg_pkg::uotg_vbus_t int_cmp,
  input  wire logic                 comparator_state_first,
  input  wire logic                 comparator_state_second,
  input  wire logic                 ext_bus_valid_in,
  input  wire logic                 ext_session_valid_in,
  input  wire logic                 ext_session_end_in,
  input  wire logic                 dp_in,
  input  wire logic                 dm_in,
  output logic                      dplus_pullup_en,
  output logic                      dminus_pullup_en,
  output logic                      dplus_pulldown_en,
  output logic                      dminus_pulldown_en,
  output logic                      vbus_power_on,
  output logic                      otg_enable,
  output logic                      vbus_charge_en,
  output logic                      vbus_discharge_en,
  output logic                      vbus_pulse_en,
  output logic                      internal_comparator_off,
  output logic                      vbus_boost_pwm
);

  localparam int IW = $clog2(IDLE_CYCLES + 1);
  localparam int FW = $clog2(FRAME_CYCLES + 1);
  localparam int DW = $clog2(uotg_pkg::DETACH_CYC + 1);

  typedef enum logic [1:0] {
    ST_DETACHED = 2'b01,
    ST_ATTACHED = 2'b10
  } uotg_line_t;

  function automatic logic [7:0] wr_byte(
    input logic [7:0] old_v,
    input logic [7:0] new_v,
    input logic       en
  );
    return en ? new_v : old_v;
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [9:0]           pin_raw;
  logic [9:0]           pin_s1_ff;
  logic [9:0]           pin_s2_ff;
  uotg_pkg::uotg_vbus_t int_s;
  uotg_pkg::uotg_ext_t  ext_s;
  logic                 dp_s;
  logic                 dm_s;

  assign pin_raw = {int_cmp,
                    comparator_state_first,
                    comparator_state_second,
                    ext_bus_valid_in,
                    ext_session_valid_in,
                    ext_session_end_in,
                    dp_in,
                    dm_in};

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_s1_ff <= 10'h000;
      pin_s2_ff <= 10'h000;
    end else begin
      pin_s1_ff <= pin_raw;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  assign int_s = pin_s2_ff[9:7];
  assign ext_s = pin_s2_ff[6:2];
  assign dp_s  = pin_s2_ff[1];
  assign dm_s  = pin_s2_ff[0];

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [7:0]  otg_ir_ff;
  logic [7:0]  usb_ir_ff;
  logic [7:0]  otg_con_ff;
  logic [7:0]  cnfg2_ff;
  logic [7:0]  bdtp_ff;
  logic [15:0] pwm_rld_ff;
  logic [15:0] pwmcon_ff;
  logic [31:0] prdata_ff;
  logic [7:0]  nxt_otg_ir;
  logic [7:0]  nxt_usb_ir;
  logic [7:0]  nxt_otg_con;
  logic [7:0]  nxt_cnfg2;
  logic [7:0]  nxt_bdtp;
  logic [15:0] nxt_pwm_rld;
  logic [15:0] nxt_pwmcon;

  // ------------------------------------------------------------
  // vbus level and events
  // ------------------------------------------------------------
  uotg_pkg::uotg_vbus_t vbus;
  uotg_pkg::uotg_vbus_t vbus_prev_ff;
  logic                 sess_end_evt;
  logic                 sess_valid_evt;

  uotg_cmp_decode u_decode (
    .cmp_disable (cnfg2_ff[uotg_pkg::BIT_CMP_DIS]),
    .cmp_select  (cnfg2_ff[uotg_pkg::BIT_CMP_SEL]),
    .int_cmp     (int_s),
    .ext         (ext_s),
    .vbus        (vbus)
  );

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      vbus_prev_ff <= 3'h0;
    end else begin
      vbus_prev_ff <= vbus;
    end
  end

  // falling below session end shows as session-end becoming true
  assign sess_end_evt   = vbus.sess_end & ~vbus_prev_ff.sess_end;
  assign sess_valid_evt = vbus.sess_valid ^ vbus_prev_ff.sess_valid;

  // ------------------------------------------------------------
  // line monitor: attach, detach, idle
  // ------------------------------------------------------------
  uotg_line_t  line_ff;
  uotg_line_t  nxt_line;
  logic [DW-1:0] se0_cnt_ff;
  logic [IW-1:0] idle_cnt_ff;
  logic [1:0]  line_prev_ff;
  logic        full_speed_ff;
  logic        se0;
  logic        se0_long;
  logic        idle_hit;
  logic        attach_evt;
  logic        detach_evt;
  logic        idle_evt;

  assign se0      = ~dp_s & ~dm_s;
  assign se0_long = se0_cnt_ff == DW'(uotg_pkg::DETACH_CYC);
  assign idle_hit = idle_cnt_ff == IW'(IDLE_CYCLES);

  always_comb begin
    nxt_line   = line_ff;
    attach_evt = 1'b0;
    detach_evt = 1'b0;
    case (line_ff)
      ST_DETACHED: begin
        if (!se0) begin
          nxt_line   = ST_ATTACHED;
          attach_evt = 1'b1;
        end
      end
      ST_ATTACHED: begin
        if (se0_long) begin
          nxt_line   = ST_DETACHED;
          detach_evt = 1'b1;
        end
      end
      default: nxt_line = ST_DETACHED;
    endcase
  end

  // flag only on reaching the count; a saturated counter stays quiet
  assign idle_evt = (idle_cnt_ff == IW'(IDLE_CYCLES - 1)) &&
                    ({dp_s, dm_s} == line_prev_ff);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      line_ff       <= ST_DETACHED;
      se0_cnt_ff    <= '0;
      idle_cnt_ff   <= '0;
      line_prev_ff  <= 2'h0;
      full_speed_ff <= 1'b0;
    end else begin
      line_ff      <= nxt_line;
      line_prev_ff <= {dp_s, dm_s};
      if (!se0) begin
        se0_cnt_ff <= '0;
      end else if (!se0_long) begin
        se0_cnt_ff <= se0_cnt_ff + DW'(1);
      end
      if ({dp_s, dm_s} != line_prev_ff) begin
        idle_cnt_ff <= '0;
      end else if (!idle_hit) begin
        idle_cnt_ff <= idle_cnt_ff + IW'(1);
      end
      // j state with d+ high marks a full-speed partner
      if (attach_evt) begin
        full_speed_ff <= dp_s & ~dm_s;
      end else if (detach_evt) begin
        full_speed_ff <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // frame number counter
  // ------------------------------------------------------------
  logic [FW-1:0]                tick_cnt_ff;
  logic [uotg_pkg::FRAME_W-1:0] frame_ff;
  logic                         frame_tick;

  assign frame_tick = tick_cnt_ff == FW'(FRAME_CYCLES - 1);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tick_cnt_ff <= '0;
      frame_ff    <= '0;
    end else if (frame_tick) begin
      tick_cnt_ff <= '0;
      frame_ff    <= frame_ff + uotg_pkg::FRAME_W'(1);
    end else begin
      tick_cnt_ff <= tick_cnt_ff + FW'(1);
    end
  end

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  logic       acc;
  logic       wr_lo;
  logic       wr_hi;
  logic       hit_otg_ir;
  logic       hit_otg_st;
  logic       hit_otg_con;
  logic       hit_cnfg2;
  logic       hit_usb_ir;
  logic       hit_bdtp;
  logic       hit_frml;
  logic       hit_frmh;
  logic       hit_pwmrrs;
  logic       hit_pwmcon;
  logic       mapped;
  logic [7:0] wbyte;
  logic [7:0] otg_ir_set;
  logic [7:0] usb_ir_set;
  logic [7:0] otg_st;
  logic [31:0] rd_mux;

  assign acc   = psel & penable;
  assign wr_lo = acc & pwrite & pstrb[0];
  assign wr_hi = acc & pwrite & pstrb[1];
  assign wbyte = pwdata[7:0];

  assign hit_otg_ir  = paddr == uotg_pkg::OFS_OTG_IR;
  assign hit_otg_st  = paddr == uotg_pkg::OFS_OTG_ST;
  assign hit_otg_con = paddr == uotg_pkg::OFS_OTG_CON;
  assign hit_cnfg2   = paddr == uotg_pkg::OFS_CNFG2;
  assign hit_usb_ir  = paddr == uotg_pkg::OFS_USB_IR;
  assign hit_bdtp    = paddr == uotg_pkg::OFS_BDTP;
  assign hit_frml    = paddr == uotg_pkg::OFS_FRML;
  assign hit_frmh    = paddr == uotg_pkg::OFS_FRMH;
  assign hit_pwmrrs  = paddr == uotg_pkg::OFS_PWMRRS;
  assign hit_pwmcon  = paddr == uotg_pkg::OFS_PWMCON;
  assign mapped = |{hit_otg_ir, hit_otg_st, hit_otg_con, hit_cnfg2, hit_usb_ir,
                    hit_bdtp, hit_frml, hit_frmh, hit_pwmrrs, hit_pwmcon};

  // zero wait states: setup latches read data, access completes
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata  = prdata_ff;

  // ------------------------------------------------------------
  // register updates
  // ------------------------------------------------------------
  always_comb begin
    otg_ir_set = 8'h00;
    otg_ir_set[uotg_pkg::BIT_SESS_END_FLAG]   = sess_end_evt;
    otg_ir_set[uotg_pkg::BIT_SESS_VALID_FLAG] = sess_valid_evt;
    usb_ir_set = 8'h00;
    usb_ir_set[uotg_pkg::BIT_RESET_FLAG]  = detach_evt;
    usb_ir_set[uotg_pkg::BIT_IDLE_FLAG]   = idle_evt;
    usb_ir_set[uotg_pkg::BIT_ATTACH_FLAG] = attach_evt;
  end

  // write-one-to-clear; a set in the same cycle survives the clear
  assign nxt_otg_ir = ((otg_ir_ff & ~wr_byte(8'h00, wbyte, wr_lo & hit_otg_ir))
                      | otg_ir_set) & uotg_pkg::MASK_OTG_IR;
  assign nxt_usb_ir = ((usb_ir_ff & ~wr_byte(8'h00, wbyte, wr_lo & hit_usb_ir))
                      | usb_ir_set) & uotg_pkg::MASK_USB_IR;

  // upper byte ignored everywhere except the two pwm registers
  assign nxt_otg_con = wr_byte(otg_con_ff, wbyte, wr_lo & hit_otg_con);
  assign nxt_cnfg2   = wr_byte(cnfg2_ff, wbyte & uotg_pkg::MASK_CNFG2,
                               wr_lo & hit_cnfg2);
  assign nxt_bdtp    = wr_byte(bdtp_ff, wbyte & uotg_pkg::MASK_BDTP,
                               wr_lo & hit_bdtp);
  assign nxt_pwm_rld = {wr_byte(pwm_rld_ff[15:8], pwdata[15:8], wr_hi & hit_pwmrrs),
                        wr_byte(pwm_rld_ff[7:0], wbyte, wr_lo & hit_pwmrrs)};
  assign nxt_pwmcon  = {wr_byte(pwmcon_ff[15:8], pwdata[15:8], wr_hi & hit_pwmcon),
                        wr_byte(pwmcon_ff[7:0], wbyte, wr_lo & hit_pwmcon)}
                       & uotg_pkg::MASK_PWMCON;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      otg_ir_ff  <= uotg_pkg::RST_BYTE;
      usb_ir_ff  <= uotg_pkg::RST_BYTE;
      otg_con_ff <= uotg_pkg::RST_BYTE;
      cnfg2_ff   <= uotg_pkg::RST_BYTE;
      bdtp_ff    <= uotg_pkg::RST_BYTE;
      pwm_rld_ff <= uotg_pkg::RST_HALF;
      pwmcon_ff  <= uotg_pkg::RST_HALF;
    end else begin
      otg_ir_ff  <= nxt_otg_ir;
      usb_ir_ff  <= nxt_usb_ir;
      otg_con_ff <= nxt_otg_con;
      cnfg2_ff   <= nxt_cnfg2;
      bdtp_ff    <= nxt_bdtp;
      pwm_rld_ff <= nxt_pwm_rld;
      pwmcon_ff  <= nxt_pwmcon;
    end
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always_comb begin
    otg_st = 8'h00;
    otg_st[uotg_pkg::BIT_ST_BUS_VALID]  = vbus.bus_valid;
    otg_st[uotg_pkg::BIT_ST_SESS_END]   = vbus.sess_end;
    otg_st[uotg_pkg::BIT_ST_SESS_VALID] = vbus.sess_valid;
    otg_st[uotg_pkg::BIT_ST_FULL_SPEED] = full_speed_ff;
    rd_mux = 32'h0000_0000;
    case (1'b1)
      hit_otg_ir:  rd_mux[7:0]  = otg_ir_ff;
      hit_otg_st:  rd_mux[7:0]  = otg_st;
      hit_otg_con: rd_mux[7:0]  = otg_con_ff;
      hit_cnfg2:   rd_mux[7:0]  = cnfg2_ff;
      hit_usb_ir:  rd_mux[7:0]  = usb_ir_ff;
      hit_bdtp:    rd_mux[7:0]  = bdtp_ff;
      hit_frml:    rd_mux[7:0]  = frame_ff[7:0];
      hit_frmh:    rd_mux[2:0]  = frame_ff[10:8];
      hit_pwmrrs:  rd_mux[15:0] = pwm_rld_ff;
      hit_pwmcon:  rd_mux[15:0] = pwmcon_ff;
      default:     rd_mux       = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_ff <= rd_mux;
    end
  end

  // ------------------------------------------------------------
  // pad controls
  // ------------------------------------------------------------
  assign dplus_pullup_en    = otg_con_ff[uotg_pkg::BIT_DP_PULLUP];
  assign dminus_pullup_en   = otg_con_ff[uotg_pkg::BIT_DM_PULLUP];
  assign dplus_pulldown_en  = otg_con_ff[uotg_pkg::BIT_DP_PULLDN];
  assign dminus_pulldown_en = otg_con_ff[uotg_pkg::BIT_DM_PULLDN];
  assign vbus_power_on      = otg_con_ff[uotg_pkg::BIT_VBUS_ON];
  assign otg_enable         = otg_con_ff[uotg_pkg::BIT_OTG_EN];
  assign vbus_charge_en     = otg_con_ff[uotg_pkg::BIT_VBUS_CHG];
  assign vbus_discharge_en  = otg_con_ff[uotg_pkg::BIT_VBUS_DIS];
  assign vbus_pulse_en      = cnfg2_ff[uotg_pkg::BIT_VBUS_PULSE];
  assign internal_comparator_off = cnfg2_ff[uotg_pkg::BIT_CMP_DIS];

  uotg_pwm #(
    .W (8)
  ) u_pwm (
    .clock   (clock),
    .rst     (rst),
    .enable  (pwmcon_ff[uotg_pkg::BIT_PWM_EN]),
    .reload  (pwm_rld_ff),
    .pwm_out (vbus_boost_pwm)
  );

endmodule // uotg_session

// File: shared/uotg_pkg.sv
package uotg_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_OTG_IR  = 8'h00;
  localparam logic [7:0] OFS_OTG_ST  = 8'h04;
  localparam logic [7:0] OFS_OTG_CON = 8'h08;
  localparam logic [7:0] OFS_CNFG2   = 8'h0C;
  localparam logic [7:0] OFS_USB_IR  = 8'h10;
  localparam logic [7:0] OFS_BDTP    = 8'h14;
  localparam logic [7:0] OFS_FRML    = 8'h18;
  localparam logic [7:0] OFS_FRMH    = 8'h1C;
  localparam logic [7:0] OFS_PWMRRS  = 8'h20;
  localparam logic [7:0] OFS_PWMCON  = 8'h24;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int BIT_SESS_END_FLAG   = 2;
  localparam int BIT_SESS_VALID_FLAG = 3;
  localparam int BIT_DP_PULLUP       = 7;
  localparam int BIT_DM_PULLUP       = 6;
  localparam int BIT_DP_PULLDN       = 5;
  localparam int BIT_DM_PULLDN       = 4;
  localparam int BIT_VBUS_ON         = 3;
  localparam int BIT_OTG_EN          = 2;
  localparam int BIT_VBUS_CHG        = 1;
  localparam int BIT_VBUS_DIS        = 0;
  localparam int BIT_CMP_SEL         = 5;
  localparam int BIT_VBUS_PULSE      = 4;
  localparam int BIT_CMP_DIS         = 1;
  localparam int BIT_RESET_FLAG      = 0;
  localparam int BIT_IDLE_FLAG       = 4;
  localparam int BIT_ATTACH_FLAG     = 6;
  localparam int BIT_ST_BUS_VALID    = 0;
  localparam int BIT_ST_SESS_END     = 2;
  localparam int BIT_ST_SESS_VALID   = 3;
  localparam int BIT_ST_FULL_SPEED   = 4;
  localparam int BIT_PWM_EN          = 15;

  // ------------------------------------------------------------
  // reset values and implemented-bit masks
  // ------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [15:0] RST_HALF    = 16'h0000;
  localparam logic [7:0]  MASK_OTG_IR = 8'h0C;
  localparam logic [7:0]  MASK_USB_IR = 8'h51;
  localparam logic [7:0]  MASK_CNFG2  = 8'h32;
  localparam logic [7:0]  MASK_BDTP   = 8'hFE;
  localparam logic [15:0] MASK_PWMCON = 16'h8000;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ    = 250;
  localparam int DETACH_NS  = 2500;
  localparam int DETACH_CYC = (DETACH_NS * CLK_MHZ + 999) / 1000;
  localparam int IDLE_MS    = 3;
  localparam int IDLE_CYC   = IDLE_MS * CLK_MHZ * 1000;
  localparam int FRAME_MS   = 1;
  localparam int FRAME_CYC  = FRAME_MS * CLK_MHZ * 1000;
  localparam int FRAME_W    = 11;

  typedef struct packed {
    logic bus_valid;
    logic sess_valid;
    logic sess_end;
  } uotg_vbus_t;

  typedef struct packed {
    logic first;
    logic second;
    logic bus_valid;
    logic sess_valid;
    logic sess_end;
  } uotg_ext_t;

endpackage

// File: hdl/uotg_cmp_decode.sv
`timescale 1ns/100ps
module uotg_cmp_decode (
  input  wire logic                 cmp_disable,
  input  wire logic                 cmp_select,
  input  wire uotg_pkg::uotg_vbus_t int_cmp,
  input  wire uotg_pkg::uotg_ext_t  ext,
  output uotg_pkg::uotg_vbus_t      vbus
);

  uotg_pkg::uotg_vbus_t two_pin;
  uotg_pkg::uotg_vbus_t three_pin;
  uotg_pkg::uotg_vbus_t ext_sel;

  // 00 below end, 10 between, 01 session valid, 11 bus valid
  assign two_pin.sess_end   = ~ext.first & ~ext.second;
  assign two_pin.sess_valid = ext.second;
  assign two_pin.bus_valid  = ext.first & ext.second;

  // pins already carry level meaning: 001, 000, 010, 110
  assign three_pin.sess_end   = ext.sess_end;
  assign three_pin.sess_valid = ext.sess_valid;
  assign three_pin.bus_valid  = ext.bus_valid;

  assign ext_sel = cmp_select ? three_pin : two_pin;
  assign vbus    = cmp_disable ? ext_sel : int_cmp;

endmodule // uotg_cmp_decode

// File: hdl/uotg_pwm.sv
`timescale 1ns/100ps
module uotg_pwm #(
  parameter int W = 8
) (
  input  wire logic           clock,
  input  wire logic           rst,
  input  wire logic           enable,
  input  wire logic [2*W-1:0] reload,
  output logic                pwm_out
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] duty_ff;
  logic [W-1:0] per_ff;
  logic         out_ff;
  logic         wrap;

  assign wrap    = cnt_ff >= per_ff;
  assign pwm_out = out_ff;

  // new reload only at period end or while disabled, so a write never makes a runt pulse
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_ff  <= '0;
      duty_ff <= '0;
      per_ff  <= '0;
      out_ff  <= 1'b0;
    end else begin
      cnt_ff <= (wrap || !enable) ? '0 : cnt_ff + W'(1);
      if (wrap || !enable) begin
        duty_ff <= reload[2*W-1:W];
        per_ff  <= reload[W-1:0];
      end
      out_ff <= enable && (cnt_ff < duty_ff);
    end
  end

endmodule // uotg_pwm

// File: tb/uotg_far_model.sv
`timescale 1ns/100ps
module uotg_far_model (
  input  wire logic            conn,
  input  wire logic            fs,
  input  wire logic [1:0]      ilvl,
  input  wire logic [1:0]      xlvl,
  output uotg_pkg::uotg_vbus_t icmp,
  output logic                 first,
  output logic                 second,
  output logic                 bvld,
  output logic                 svld,
  output logic                 send,
  output logic                 dp,
  output logic                 dm
);
  // ----
  // cable side levels
  // ----
  // detached: host pull-downs hold SE0, so the idle level is a real low
  assign dp = conn & fs;
  assign dm = conn & ~fs;
  assign icmp = {ilvl == 2'h3, ilvl[1], ilvl == 2'h0};
  assign {first, second} = {xlvl[0], xlvl[1]};
  assign {bvld, svld, send} = {xlvl == 2'h3, xlvl[1], xlvl == 2'h0};
endmodule // uotg_far_model

// File: tb/uotg_session_sva.sv
`timescale 1ns/100ps
module uotg_session_sva (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        dplus_pullup_en,
  input wire logic        dminus_pullup_en,
  input wire logic        vbus_discharge_en,
  input wire logic        vbus_pulse_en,
  input wire logic        internal_comparator_off
);
  // ----
  // access decode
  // ----
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  wire wr  = psel & penable & pwrite & pstrb[0];
  wire rd  = psel & penable & ~pwrite;
  wire wcn = wr && paddr == uotg_pkg::OFS_OTG_CON;
  wire wc2 = wr && paddr == uotg_pkg::OFS_CNFG2;
  wire pwm = paddr == uotg_pkg::OFS_PWMRRS || paddr == uotg_pkg::OFS_PWMCON;
  wire [1:0] pu = {dplus_pullup_en, dminus_pullup_en};
  wire rfh = rd && paddr == uotg_pkg::OFS_FRMH;
  // ----
  // properties
  // ----
  a_dis_follow: assert property (wcn |=> vbus_discharge_en == $past(pwdata[0]))
    else $error("discharge enable wrong");
  a_ctl_hold: assert property ($changed(vbus_discharge_en) |-> $past(wcn))
    else $error("discharge changed without write");
  a_pu_follow: assert property (wcn |=> pu == $past(pwdata[7:6]))
    else $error("pull-up enables wrong");
  a_pulse_follow: assert property (wc2 |=> vbus_pulse_en == $past(pwdata[4]))
    else $error("vbus pulse wrong");
  a_cmp_follow: assert property (wc2 |=> internal_comparator_off == $past(pwdata[1]))
    else $error("comparator off wrong");
  a_low_byte: assert property (rd && !pwm |-> prdata[31:8] == 24'h000000)
    else $error("upper bits set");
  a_page_b0: assert property (rd && paddr == uotg_pkg::OFS_BDTP |-> !prdata[0])
    else $error("page bit 0 set");
  a_frm_width: assert property (rfh |-> prdata[7:3] == 5'h00)
    else $error("frame number too wide");
  c_con_wr: cover property (wcn);
  c_cfg_wr: cover property (wc2);
  c_pwm_rd: cover property (rd && pwm);
endmodule // uotg_session_sva
bind uotg_session uotg_session_sva chk (.clock, .rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .prdata, .dplus_pullup_en, .dminus_pullup_en, .vbus_discharge_en,
  .vbus_pulse_en, .internal_comparator_off);

// File: tb/test_usb_otg_session_role_negotiation.sv
`timescale 1ns/100ps
module test_usb_otg_session_role_negotiation;
  // ----
  // stimulus and wiring
  // ----
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic        conn = 1'b0;
  logic        fs = 1'b0;
  logic [1:0]  ilvl = 2'h0;
  logic [1:0]  xlvl = 2'h0;
  logic [31:0] q;
  logic [31:0] n;
  logic        last_err;
  int          err_total = 0;
  int          cmp_count = 0;
  localparam logic [3:0] EXP [4] = '{4'h4, 4'h0, 4'h8, 4'h9};
  wire logic [31:0] prdata;
  wire uotg_pkg::uotg_vbus_t int_cmp;
  wire logic pready, pslverr, c1, c2, bv, sv, se, dp_in, dm_in, dplus_pullup_en;
  wire logic dminus_pullup_en, vbus_discharge_en, vbus_pulse_en, internal_comparator_off;
  wire logic vbus_boost_pwm;
  wire logic dplus_pulldown_en, dminus_pulldown_en, vbus_power_on, otg_enable, vbus_charge_en;
  wire logic [7:0] pads = {dplus_pullup_en, dminus_pullup_en, dplus_pulldown_en,
    dminus_pulldown_en, vbus_power_on, otg_enable, vbus_charge_en, vbus_discharge_en};
  uotg_session #(.IDLE_CYCLES(50), .FRAME_CYCLES(20)) uut (
    .clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata,
    .pslverr, .int_cmp, .comparator_state_first(c1), .comparator_state_second(c2),
    .ext_bus_valid_in(bv), .ext_session_valid_in(sv), .ext_session_end_in(se), .dp_in,
    .dm_in, .dplus_pullup_en, .dminus_pullup_en, .dplus_pulldown_en,
    .dminus_pulldown_en, .vbus_power_on, .otg_enable, .vbus_charge_en,
    .vbus_discharge_en, .vbus_pulse_en, .internal_comparator_off, .vbus_boost_pwm);
  uotg_far_model far (.conn, .fs, .ilvl, .xlvl, .icmp(int_cmp), .first(c1), .second(c2),
    .bvld(bv), .svld(sv), .send(se), .dp(dp_in), .dm(dm_in));
  initial begin
    forever #2 clock = ~clock;
  end
  // ----
  // bus tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wrt(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    apb(1'b1, a, d, s);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(q & m, e);
  endtask
  task automatic test_done;
    $display("mismatches %0d, checks %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    rdc(uotg_pkg::OFS_OTG_CON, 32'hFFFFFFFF, 32'h0);
    wrt(uotg_pkg::OFS_OTG_CON, 32'hFFFFFFBF, 4'hF);
    rdc(uotg_pkg::OFS_OTG_CON, 32'hFFFFFFFF, 32'hBF);
    chk({dplus_pullup_en, dminus_pullup_en, vbus_discharge_en}, 32'h5);
    chk(pads, 32'hBF);
    wrt(uotg_pkg::OFS_OTG_CON, 32'h40, 4'h1);
    // pad levels settle only after the edge that lands the write
    @(posedge clock);
    chk({dplus_pullup_en, dminus_pullup_en, vbus_discharge_en}, 32'h2);
    chk(pads, 32'h40);
    wrt(uotg_pkg::OFS_CNFG2, 32'hFFFFFFFF, 4'hF);
    rdc(uotg_pkg::OFS_CNFG2, 32'hFFFFFFFF, 32'h32);
    chk({vbus_pulse_en, internal_comparator_off}, 32'h3);
    // the unused source sits at the mirror level so a wrong mux shows
    for (int m = 0; m < 3; m++) begin
      wrt(uotg_pkg::OFS_CNFG2, m == 0 ? 32'h0 : m == 1 ? 32'h2 : 32'h22, 4'h1);
      for (int l = 0; l < 4; l++) begin
        ilvl <= m == 0 ? 2'(l) : 2'(3 - l);
        xlvl <= m == 0 ? 2'(3 - l) : 2'(l);
        repeat (6) @(posedge clock);
        rdc(uotg_pkg::OFS_OTG_ST, 32'hD, 32'(EXP[l]));
      end
    end
    xlvl <= 2'h1;
    repeat (6) @(posedge clock);
    wrt(uotg_pkg::OFS_OTG_IR, 32'hC, 4'h1);
    rdc(uotg_pkg::OFS_OTG_IR, 32'hC, 32'h0);
    xlvl <= 2'h0;
    repeat (6) @(posedge clock);
    rdc(uotg_pkg::OFS_OTG_IR, 32'h4, 32'h4);
    xlvl <= 2'h2;
    repeat (6) @(posedge clock);
    rdc(uotg_pkg::OFS_OTG_IR, 32'hC, 32'hC);
    wrt(uotg_pkg::OFS_USB_IR, 32'h51, 4'h1);
    conn <= 1'b1;
    fs <= 1'b1;
    repeat (6) @(posedge clock);
    rdc(uotg_pkg::OFS_USB_IR, 32'h40, 32'h40);
    rdc(uotg_pkg::OFS_OTG_ST, 32'h10, 32'h10);
    repeat (60) @(posedge clock);
    rdc(uotg_pkg::OFS_USB_IR, 32'h10, 32'h10);
    conn <= 1'b0;
    repeat (590) @(posedge clock);
    rdc(uotg_pkg::OFS_USB_IR, 32'h1, 32'h0);
    repeat (50) @(posedge clock);
    rdc(uotg_pkg::OFS_USB_IR, 32'h1, 32'h1);
    wrt(uotg_pkg::OFS_BDTP, 32'hFF, 4'h1);
    rdc(uotg_pkg::OFS_BDTP, 32'hFFFFFFFF, 32'hFE);
    rdc(uotg_pkg::OFS_FRML, 32'hFFFFFF00, 32'h0);
    n = q;
    // the two low reads load 80 cycles apart: four whole frames at the bench setting
    repeat (74) @(posedge clock);
    rdc(uotg_pkg::OFS_FRMH, 32'hFFFFFFF8, 32'h0);
    rdc(uotg_pkg::OFS_FRML, 32'hFFFFFF00, 32'h0);
    chk(8'(q - n), 32'h4);
    wrt(uotg_pkg::OFS_PWMRRS, 32'hFFFF0103, 4'h3);
    rdc(uotg_pkg::OFS_PWMRRS, 32'hFFFFFFFF, 32'h0103);
    wrt(uotg_pkg::OFS_PWMCON, 32'h8000, 4'h3);
    repeat (8) @(posedge clock);
    n = 0;
    repeat (40) @(posedge clock) n = n + vbus_boost_pwm;
    chk(n, 32'h0000000A);
    rdc(8'h40, 32'hFFFFFFFF, 32'h0);
    chk(last_err, 32'h1);
    test_done;
  end
  initial begin
    repeat (10000) @(posedge clock);
    err_total++;
    test_done;
  end
endmodule // test_usb_otg_session_role_negotiation
